// ---- rtl/mcp_port.sv ----
// coprocessor side of the host port: opcode tracking, address capture,
// bus borrowing and a small numeric core over an 8 x 80-bit register file.
// assumes the host drives queue status and fetched bytes synchronous to core_clk_i.
`timescale 1ns/1ps
`default_nettype none
module mcp_port
	import mcp_pkg::*;
(
	// clock and reset
	input  wire logic         core_clk_i,
	input  wire logic         rst_i,
	// instruction stream snoop
	input  wire logic         queue_status_bit_low_i,
	input  wire logic         queue_status_bit_high_i,
	input  wire logic [7:0]   fetch_byte_i,
	// host cooperation
	input  wire logic         host_addr_valid_i,
	input  wire logic [19:0]  host_addr_i,
	input  wire logic         host_instr_done_i,
	input  wire logic         fixed_set_mode_i,
	output logic              busy_o,
	// local bus ownership
	output logic              bus_req_o,
	input  wire logic         bus_grant_i,
	output logic              bus_own_o,
	// memory transfer
	output mcp_mem_req_t      mem_req_o,
	input  wire logic [15:0]  mem_rdata_i,
	input  wire logic         mem_ack_i,
	// visible state
	output logic      [2:0]   stack_top_o
);

	// ----------------------------------------------------------------
	// state and storage
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		MCP_S_IDLE,      // waiting for own opcode
		MCP_S_MODRM,     // waiting for second byte
		MCP_S_ADDR,      // waiting for host address
		MCP_S_RD_A,      // read source register
		MCP_S_RD_B,      // catch source, read destination
		MCP_S_RD_C,      // catch destination
		MCP_S_EXEC,      // numeric work in progress
		MCP_S_REQ,       // asking for the local bus
		MCP_S_XFER,      // owning the bus, moving words
		MCP_S_WB         // write result back
	} mcp_state_t;

	mcp_state_t    state_q;                  // main sequencer
	logic [7:0]    op_byte_q;                // first opcode byte
	logic [7:0]    modrm_q;                  // second byte
	logic          done_seen_q;              // host finished its instruction
	logic [2:0]    top_q;                    // stack top pointer
	logic [79:0]   src_q;                    // source operand
	logic [79:0]   dst_q;                    // destination / result
	logic [79:0]   buf_q;                    // load assembly buffer
	logic [2:0]    wcnt_q;                   // words moved so far
	logic [3:0]    exec_cnt_q;               // numeric latency countdown
	mcp_mem_req_t  mem_req_q;                // registered bus request
	logic [79:0]   rd_data;                  // register file read data
	logic          rf_wr_en;                 // register file write strobe
	logic [2:0]    rf_wr_idx;                // register file write index
	logic [79:0]   rf_wr_data;               // register file write data
	logic [2:0]    rf_rd_idx;                // register file read index

	// ----------------------------------------------------------------
	// decode of the captured instruction
	// ----------------------------------------------------------------
	logic [1:0]    qs;                       // queue status code
	logic [2:0]    fmt;                      // operand format
	logic [2:0]    mop;                      // operation field
	logic [2:0]    rm;                       // register field
	logic          is_store;                 // memory form writes memory
	logic [2:0]    src_idx;                  // source register
	logic [2:0]    dst_idx;                  // destination register
	logic [2:0]    words;                    // words for this format
	logic          last_word;                // current word is the last

	assign qs        = {queue_status_bit_high_i, queue_status_bit_low_i};   // RQ10
	assign fmt       = op_byte_q[2:0];                                      // RQ8
	assign mop       = modrm_q[5:3];
	assign rm        = modrm_q[2:0];
	assign is_store  = mop[0];
	assign words     = mcp_fmt_words(fmt);                                  // RQ9
	assign last_word = (wcnt_q + 3'h1) == words;

	// stack use sees only the top two entries; fixed use any register
	always_comb
	begin
		if (fixed_set_mode_i)
		begin
			src_idx = top_q;                                                  // RQ7
			dst_idx = rm;                                                     // RQ7
		end
		else
		begin
			src_idx = top_q + 3'h1;                                           // RQ7
			dst_idx = top_q;                                                  // RQ7
		end
	end

	// ----------------------------------------------------------------
	// main sequencer
	// ----------------------------------------------------------------
	// host is never stalled here; it only waits if it chooses to test busy
	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
		begin
			state_q <= MCP_S_IDLE;
		end
		else
		begin
			case (state_q)
				MCP_S_IDLE:
				begin
					// data bytes that look like the prefix are ignored
					if (qs == MCP_QS_FIRST && fetch_byte_i[7:3] == MCP_ESC_PREFIX)   // RQ1 RQ12
						state_q <= MCP_S_MODRM;
				end
				MCP_S_MODRM:
				begin
					if (qs == MCP_QS_FLUSH)
						state_q <= MCP_S_IDLE;
					else if (qs == MCP_QS_NEXT)
						state_q <= (fetch_byte_i[7:6] == MCP_MOD_REG) ? MCP_S_RD_A : MCP_S_ADDR;
				end
				MCP_S_ADDR:
				begin
					// stores fetch the top register before the bus is taken
					if (host_addr_valid_i)                                            // RQ2
						state_q <= is_store ? MCP_S_RD_A : MCP_S_REQ;
				end
				MCP_S_RD_A:
					state_q <= MCP_S_RD_B;
				MCP_S_RD_B:
					state_q <= (modrm_q[7:6] == MCP_MOD_REG) ? MCP_S_RD_C : MCP_S_REQ;
				MCP_S_RD_C:
					state_q <= MCP_S_EXEC;
				MCP_S_EXEC:
				begin
					if (exec_cnt_q == 4'h0)                                           // RQ5
						state_q <= MCP_S_WB;
				end
				MCP_S_REQ:
				begin
					if (done_seen_q && bus_grant_i)                                   // RQ3
						state_q <= MCP_S_XFER;
				end
				MCP_S_XFER:
				begin
					// leaving here drops ownership at once
					if (mem_ack_i && last_word)                                       // RQ4
						state_q <= is_store ? MCP_S_IDLE : MCP_S_WB;
				end
				MCP_S_WB:
					state_q <= MCP_S_IDLE;
				default:
					state_q <= MCP_S_IDLE;
			endcase
		end
	end

	// capture of the two instruction bytes
	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
		begin
			op_byte_q <= 8'h00;
			modrm_q   <= 8'h00;
		end
		else if (state_q == MCP_S_IDLE && qs == MCP_QS_FIRST)
		begin
			op_byte_q <= fetch_byte_i;                                          // RQ12
		end
		else if (state_q == MCP_S_MODRM && qs == MCP_QS_NEXT)
		begin
			modrm_q <= fetch_byte_i;
		end
	end

	// host completion marker; a pulse in the clearing cycle is kept
	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
			done_seen_q <= 1'b0;
		else if (host_instr_done_i)
			done_seen_q <= 1'b1;                                                // RQ3
		else if (state_q == MCP_S_IDLE)
			done_seen_q <= 1'b0;
	end

	// ----------------------------------------------------------------
	// operands and numeric work
	// ----------------------------------------------------------------
	// raw two's complement arithmetic over the full width; no rounding
	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
		begin
			src_q      <= 80'h0;
			dst_q      <= 80'h0;
			exec_cnt_q <= 4'h0;
		end
		else
		begin
			case (state_q)
				MCP_S_RD_B:
					src_q <= rd_data;
				MCP_S_RD_C:
				begin
					dst_q      <= rd_data;
					exec_cnt_q <= MCP_EXEC_CYC;
				end
				MCP_S_EXEC:
				begin
					exec_cnt_q <= exec_cnt_q - 4'h1;                                // RQ5
					if (exec_cnt_q == 4'h0)
					begin
						case (mop)
							MCP_OP_ADD: dst_q <= dst_q + src_q;
							MCP_OP_SUB: dst_q <= dst_q - src_q;
							MCP_OP_MOV: dst_q <= src_q;
							MCP_OP_CLR: dst_q <= 80'h0;
							default:    dst_q <= dst_q;
						endcase
					end
				end
				default:
					exec_cnt_q <= exec_cnt_q;
			endcase
		end
	end

	// stack pointer: a load pushes downward, a store pops upward
	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
			top_q <= MCP_TOP_RST;
		else if (state_q == MCP_S_WB && modrm_q[7:6] != MCP_MOD_REG)
			top_q <= top_q - 3'h1;                                              // RQ7
		else if (state_q == MCP_S_XFER && mem_ack_i && last_word && is_store)
			top_q <= top_q + 3'h1;                                              // RQ7
	end

	// ----------------------------------------------------------------
	// memory transfer on the borrowed bus
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
		begin
			mem_req_q <= '0;
			wcnt_q    <= 3'h0;
			buf_q     <= 80'h0;
		end
		else if (state_q == MCP_S_ADDR && host_addr_valid_i)
		begin
			mem_req_q.addr <= host_addr_i;                                      // RQ2
			wcnt_q         <= 3'h0;
		end
		else if (state_q == MCP_S_REQ && done_seen_q && bus_grant_i)
		begin
			mem_req_q.rd    <= ~is_store;                                       // RQ3
			mem_req_q.wr    <= is_store;
			mem_req_q.wdata <= src_q[15:0];
		end
		else if (state_q == MCP_S_XFER && mem_ack_i)
		begin
			if (!is_store)
				buf_q[wcnt_q*16 +: 16] <= mem_rdata_i;
			if (last_word)
			begin
				mem_req_q.rd <= 1'b0;                                           // RQ4
				mem_req_q.wr <= 1'b0;                                           // RQ4
			end
			else
			begin
				mem_req_q.addr  <= mem_req_q.addr + MCP_ADDR_STEP;
				mem_req_q.wdata <= src_q[(wcnt_q + 3'h1)*16 +: 16];
			end
			wcnt_q <= wcnt_q + 3'h1;
		end
	end

	// ----------------------------------------------------------------
	// register file hookup
	// ----------------------------------------------------------------
	always_comb
	begin
		rf_rd_idx  = (state_q == MCP_S_RD_B) ? dst_idx : src_idx;
		rf_wr_en   = (state_q == MCP_S_WB);
		rf_wr_idx  = dst_idx;
		rf_wr_data = dst_q;
		// loads push into the slot below the top
		if (modrm_q[7:6] != MCP_MOD_REG)
		begin
			rf_wr_idx  = top_q - 3'h1;
			rf_wr_data = mcp_widen(fmt, buf_q);                                 // RQ9
		end
		// stores read the top whatever the mode
		if (modrm_q[7:6] != MCP_MOD_REG && state_q == MCP_S_RD_A)
			rf_rd_idx = top_q;
	end

	mcp_regfile u_regfile (
		.core_clk_i (core_clk_i),
		.wr_en_i    (rf_wr_en),
		.wr_idx_i   (rf_wr_idx),
		.wr_data_i  (rf_wr_data),
		.rd_idx_i   (rf_rd_idx),
		.rd_data_o  (rd_data)
	);

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign busy_o      = (state_q != MCP_S_IDLE) && (state_q != MCP_S_MODRM);   // RQ11
	assign bus_req_o   = (state_q == MCP_S_REQ) || (state_q == MCP_S_XFER);
	assign bus_own_o   = (state_q == MCP_S_XFER);                               // RQ4
	assign mem_req_o   = mem_req_q;
	assign stack_top_o = top_q;

endmodule
`default_nettype wire

// ---- common/mcp_pkg.sv ----
// shared constants, types and decode helpers for the coprocessor host port.
// assumes one 20 MHz clock shared with the host and a 16-bit local bus.
// Operation
// RQ1: own opcode only when top five bits match
// RQ2: host computes address; we capture it for memory
// RQ3: take bus only after host instruction completes
// RQ4: release bus once memory transfer finishes
// RQ5: compute concurrently; host keeps running meanwhile
// RQ6: eight registers, each 80 bits wide
// RQ7: stack use top two; fixed use any
// RQ8: seven formats: three integer, one decimal, three real
// RQ9: widths 16/32/64 int, 80 bcd, 32/64/80 real
// RQ10: host queue status lines let us track stream
// RQ11: busy high while executing; host wait stalls
// RQ12: sample opcodes only on first-byte queue status
package mcp_pkg;

	// ----------------------------------------------------------------
	// opcode recognition and queue status
	// ----------------------------------------------------------------
	localparam logic [4:0] MCP_ESC_PREFIX = 5'h1b;   // binary 11011
	localparam logic [1:0] MCP_QS_NONE    = 2'h0;    // no queue activity
	localparam logic [1:0] MCP_QS_FIRST   = 2'h1;    // first opcode byte
	localparam logic [1:0] MCP_QS_FLUSH   = 2'h2;    // queue emptied
	localparam logic [1:0] MCP_QS_NEXT    = 2'h3;    // subsequent byte
	localparam logic [1:0] MCP_MOD_REG    = 2'h3;    // mod field: register form

	// ----------------------------------------------------------------
	// register file and numeric formats
	// ----------------------------------------------------------------
	localparam int         MCP_REG_W      = 80;      // register width
	localparam int         MCP_REG_N      = 8;       // register count
	localparam logic [2:0] MCP_FMT_INT16  = 3'h0;    // word integer
	localparam logic [2:0] MCP_FMT_INT32  = 3'h1;    // short integer
	localparam logic [2:0] MCP_FMT_INT64  = 3'h2;    // long integer
	localparam logic [2:0] MCP_FMT_BCD80  = 3'h3;    // packed decimal
	localparam logic [2:0] MCP_FMT_REAL32 = 3'h4;    // short real
	localparam logic [2:0] MCP_FMT_REAL64 = 3'h5;    // long real
	localparam logic [2:0] MCP_FMT_REAL80 = 3'h6;    // temporary real

	// register-form operations (reg field of second byte)
	localparam logic [2:0] MCP_OP_ADD     = 3'h0;
	localparam logic [2:0] MCP_OP_SUB     = 3'h1;
	localparam logic [2:0] MCP_OP_MOV     = 3'h2;
	localparam logic [2:0] MCP_OP_CLR     = 3'h3;

	// ----------------------------------------------------------------
	// reset values and cycle counts
	// ----------------------------------------------------------------
	localparam logic [2:0] MCP_TOP_RST    = 3'h0;    // stack top after reset
	localparam logic [3:0] MCP_EXEC_CYC   = 4'h8;    // numeric work latency
	localparam logic [19:0] MCP_ADDR_STEP = 20'h2;   // one 16-bit word

	// memory request toward the local bus
	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [19:0] addr;
		logic [15:0] wdata;
	} mcp_mem_req_t;

	// number of 16-bit words a memory format occupies
	function automatic logic [2:0] mcp_fmt_words(input logic [2:0] fmt);
		case (fmt)
			MCP_FMT_INT16:  mcp_fmt_words = 3'h1;
			MCP_FMT_INT32:  mcp_fmt_words = 3'h2;
			MCP_FMT_REAL32: mcp_fmt_words = 3'h2;
			MCP_FMT_INT64:  mcp_fmt_words = 3'h4;
			MCP_FMT_REAL64: mcp_fmt_words = 3'h4;
			default:        mcp_fmt_words = 3'h5;
		endcase
	endfunction

	// widen a loaded operand to register width
	function automatic logic [79:0] mcp_widen(input logic [2:0] fmt, input logic [79:0] raw);
		case (fmt)
			MCP_FMT_INT16:  mcp_widen = {{64{raw[15]}}, raw[15:0]};
			MCP_FMT_INT32:  mcp_widen = {{48{raw[31]}}, raw[31:0]};
			MCP_FMT_INT64:  mcp_widen = {{16{raw[63]}}, raw[63:0]};
			MCP_FMT_REAL32: mcp_widen = {48'h0, raw[31:0]};
			MCP_FMT_REAL64: mcp_widen = {16'h0, raw[63:0]};
			default:        mcp_widen = raw;
		endcase
	endfunction

endpackage

// ---- rtl/mcp_regfile.sv ----
// eight-entry by 80-bit register file of the coprocessor.
// assumes one write and one read per cycle; read data is registered.
`timescale 1ns/1ps
`default_nettype none
module mcp_regfile
	import mcp_pkg::*;
(
	// clock
	input  wire logic         core_clk_i,
	// write port
	input  wire logic         wr_en_i,
	input  wire logic [2:0]   wr_idx_i,
	input  wire logic [79:0]  wr_data_i,
	// read port, data one cycle later
	input  wire logic [2:0]   rd_idx_i,
	output logic      [79:0]  rd_data_o
);

	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	logic [MCP_REG_W-1:0] mem_q [MCP_REG_N];   // RQ6

	// write; contents are left undefined by reset like the real part
	always_ff @(posedge core_clk_i)
	begin
		if (wr_en_i)
		begin
			mem_q[wr_idx_i] <= wr_data_i;
		end
	end

	// registered read
	always_ff @(posedge core_clk_i)
	begin
		rd_data_o <= mem_q[rd_idx_i];
	end

endmodule
`default_nettype wire

// ---- test/mcp_port_monitor.sv ----
// concurrent checks on the coprocessor host port, seen only from its pins.
// assumes the bind below attaches it to every mcp_port instance.
`timescale 1ns/1ps
`default_nettype none
module mcp_port_monitor
	import mcp_pkg::*;
(
	// clock and reset
	input wire logic          core_clk_i,
	input wire logic          rst_i,
	// snoop and host side
	input wire logic          queue_status_bit_low_i,
	input wire logic          queue_status_bit_high_i,
	input wire logic [7:0]    fetch_byte_i,
	input wire logic          host_addr_valid_i,
	input wire logic [19:0]   host_addr_i,
	input wire logic          host_instr_done_i,
	input wire logic          fixed_set_mode_i,
	input wire logic          busy_o,
	// bus side
	input wire logic          bus_req_o,
	input wire logic          bus_grant_i,
	input wire logic          bus_own_o,
	input wire mcp_mem_req_t  mem_req_o,
	input wire logic [15:0]   mem_rdata_i,
	input wire logic          mem_ack_i,
	input wire logic [2:0]    stack_top_o
);
	// ----------------------------------------------------------------
	// clocking and helpers
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	wire logic [1:0] qs  = {queue_status_bit_high_i, queue_status_bit_low_i};   // queue status pair
	wire logic       stb = mem_req_o.rd || mem_req_o.wr;                        // word strobe

	// idle prefixed first byte followed by its second byte
	sequence s_own_first;
		!busy_o && qs == MCP_QS_FIRST && fetch_byte_i[7:3] == MCP_ESC_PREFIX ##1 qs == MCP_QS_NEXT;
	endsequence
	// same, second byte selects the register form
	sequence s_reg_form;
		s_own_first ##0 fetch_byte_i[7:6] == MCP_MOD_REG;
	endsequence

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	AST_CLAIM: assert property (s_own_first |=> busy_o)
		else $error("prefixed opcode not claimed");
	AST_FOREIGN: assert property (!busy_o && qs == MCP_QS_FIRST && fetch_byte_i[7:3] != MCP_ESC_PREFIX |=> ##1 !busy_o)
		else $error("foreign opcode claimed");
	AST_DATA_BYTE: assert property (!busy_o && qs == MCP_QS_NEXT && $past(qs) != MCP_QS_FIRST |=> !busy_o)
		else $error("data byte started decode");
	AST_REG_LEN: assert property (s_reg_form |=> busy_o[*8] ##5 busy_o ##1 !busy_o)
		else $error("register form busy length wrong");
	AST_OWN_REQ: assert property (bus_own_o |-> bus_req_o && busy_o)
		else $error("bus owned without request");
	AST_OWN_GRANT: assert property ($rose(bus_own_o) |-> $past(bus_grant_i) && $past(bus_req_o))
		else $error("bus taken without grant");
	AST_STROBE_OWNED: assert property (stb |-> bus_own_o)
		else $error("strobe outside ownership");
	AST_HOLD: assert property (stb && !mem_ack_i |=> $stable(mem_req_o))
		else $error("request changed before ack");
	AST_STEP: assert property (stb && mem_ack_i ##1 stb |-> mem_req_o.addr == $past(mem_req_o.addr) + MCP_ADDR_STEP)
		else $error("word address did not step");
	AST_RELEASE: assert property ($fell(bus_own_o) |-> $past(mem_ack_i) ##1 !bus_req_o)
		else $error("bus not returned after last ack");
	AST_IDLE_NO_BUS: assert property (!busy_o |-> !bus_req_o)
		else $error("bus wanted while not busy");
	// reset check runs with reset itself as its trigger
	AST_QUIET: assert property (disable iff (1'b0) rst_i |=> !busy_o && !bus_req_o && !bus_own_o && mem_req_o == '0
		&& stack_top_o == MCP_TOP_RST)
		else $error("outputs not cleared by reset");
endmodule
bind mcp_port mcp_port_monitor i_mon (.core_clk_i, .rst_i, .queue_status_bit_low_i, .queue_status_bit_high_i,
	.fetch_byte_i, .host_addr_valid_i, .host_addr_i, .host_instr_done_i, .fixed_set_mode_i, .busy_o, .bus_req_o,
	.bus_grant_i, .bus_own_o, .mem_req_o, .mem_rdata_i, .mem_ack_i, .stack_top_o);
`default_nettype wire

// ---- test/mcp_host_model.sv ----
// host memory model on the local bus: answers one word per ack.
// assumes the bench drives grant and done; latency comes from lat_i.
`timescale 1ns/1ps
`default_nettype none
module mcp_host_model
	import mcp_pkg::*;
(
	// clock and reset
	input wire logic          core_clk_i,
	input wire logic          rst_i,
	// transfer from the coprocessor
	input wire logic          bus_own_i,
	input wire mcp_mem_req_t  mem_req_i,
	input wire logic [3:0]    lat_i,
	// answer
	output logic              mem_ack_o,
	output logic [15:0]       mem_rdata_o
);
	logic [15:0] mem_q [0:63];   // word store, aliased by address bits 6:1
	logic [3:0]  wait_q;         // latency counter
	logic [15:0] last_q;         // last word put on the bus
	wire logic [5:0] idx = mem_req_i.addr[6:1];

	// ----------------------------------------------------------------
	// word handshake
	// ----------------------------------------------------------------
	// ack is a one-cycle pulse; a fresh count starts for the next word
	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
		begin
			wait_q    <= 4'h0;
			mem_ack_o <= 1'b0;
			for (int i = 0; i < 64; i++)
				mem_q[i] <= 16'h8000 | 16'(i);   // top bit set to show sign extension
		end
		else
		begin
			mem_ack_o <= 1'b0;
			if (bus_own_i && (mem_req_i.rd || mem_req_i.wr) && !mem_ack_o)
			begin
				if (wait_q == lat_i)
				begin
					mem_ack_o <= 1'b1;
					wait_q    <= 4'h0;
					if (mem_req_i.wr)
						mem_q[idx] <= mem_req_i.wdata;
				end
				else
					wait_q <= wait_q + 4'h1;
			end
		end
	end

	// released data shows the inverse of the last word, never a stale copy
	always_ff @(posedge core_clk_i)
		if (mem_ack_o)
			last_q <= mem_q[idx];
	assign mem_rdata_o = mem_ack_o ? mem_q[idx] : ~last_q;
endmodule
`default_nettype wire

// ---- test/mcp_port_tb_top.sv ----
// self-checking bench for the coprocessor host port with a host memory model.
// assumes the model acks each word after a latency set per transfer.
`timescale 1ns/1ps
`default_nettype none
module mcp_port_tb_top
	import mcp_pkg::*;
;
	// ----------------------------------------------------------------
	// stimulus and observed signals
	// ----------------------------------------------------------------
	logic core_clk_i = 0, rst_i = 1, queue_status_bit_low_i = 0, queue_status_bit_high_i = 0;
	logic [7:0] fetch_byte_i = 8'h00;
	logic host_addr_valid_i = 0, host_instr_done_i = 0, fixed_set_mode_i = 0, bus_grant_i = 0;
	logic [19:0] host_addr_i = 20'h00000;
	logic [3:0] lat = 4'h0;   // model answer latency
	logic busy_o, bus_req_o, bus_own_o, mem_ack_i;
	logic [15:0] mem_rdata_i;
	logic [2:0] stack_top_o;
	mcp_mem_req_t mem_req_o;
	int err_count = 0, n_tests = 0, exp_top = 0;
	int words [7] = '{1, 2, 4, 5, 2, 4, 5};   // words per format code

	mcp_port i_dut (.core_clk_i, .rst_i, .queue_status_bit_low_i, .queue_status_bit_high_i, .fetch_byte_i,
		.host_addr_valid_i, .host_addr_i, .host_instr_done_i, .fixed_set_mode_i, .busy_o, .bus_req_o,
		.bus_grant_i, .bus_own_o, .mem_req_o, .mem_rdata_i, .mem_ack_i, .stack_top_o);
	mcp_host_model i_host (.core_clk_i, .rst_i, .bus_own_i(bus_own_o), .mem_req_i(mem_req_o), .lat_i(lat),
		.mem_ack_o(mem_ack_i), .mem_rdata_o(mem_rdata_i));

	always #25 core_clk_i = ~core_clk_i;

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			err_count++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// inputs always change 2 ns after a rising edge
	task automatic tick(int n);
		repeat (n) @(posedge core_clk_i);
		#2;
	endtask
	// host fetches a two-byte instruction; status tells which byte is first
	task automatic issue(logic [7:0] b1, logic [7:0] b2);
		{queue_status_bit_high_i, queue_status_bit_low_i} = MCP_QS_FIRST;
		fetch_byte_i = b1;
		tick(1);
		{queue_status_bit_high_i, queue_status_bit_low_i} = MCP_QS_NEXT;
		fetch_byte_i = b2;
		tick(1);
		{queue_status_bit_high_i, queue_status_bit_low_i} = MCP_QS_NONE;
		fetch_byte_i = 8'h00;
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	// foreign opcode and a prefix-like data byte leave the port idle
	task automatic t_foreign;
		issue(8'hd7, 8'hc0);
		tick(2);
		check("busy_o foreign", busy_o, 0);
		{queue_status_bit_high_i, queue_status_bit_low_i} = MCP_QS_NEXT;
		fetch_byte_i = 8'hd8;
		tick(1);
		{queue_status_bit_high_i, queue_status_bit_low_i} = MCP_QS_NONE;
		tick(2);
		check("busy_o data byte", busy_o, 0);
		// a flush between the two bytes abandons the instruction
		{queue_status_bit_high_i, queue_status_bit_low_i} = MCP_QS_FIRST;
		fetch_byte_i = 8'hd8;
		tick(1);
		{queue_status_bit_high_i, queue_status_bit_low_i} = MCP_QS_FLUSH;
		tick(1);
		{queue_status_bit_high_i, queue_status_bit_low_i} = MCP_QS_NEXT;
		fetch_byte_i = 8'hc0;
		tick(1);
		{queue_status_bit_high_i, queue_status_bit_low_i} = MCP_QS_NONE;
		tick(2);
		check("busy_o flush", busy_o, 0);
	endtask
	// register form in both register uses; host keeps fetching meanwhile
	task automatic t_regop;
		int n;
		for (int m = 0; m < 2; m++)
		begin
			fixed_set_mode_i = m[0];
			issue(8'hd8, m ? 8'hda : 8'hc1);
			check("busy_o start", busy_o, 1);
			tick(1);
			issue(8'hd9, 8'hc0);   // ignored while busy
			n = 0;
			while (busy_o && n < 40)
			begin
				n++;
				tick(1);
			end
			check("busy cycles", n + 3, 13);
			check("stack_top_o reg", stack_top_o, exp_top[2:0]);
		end
	endtask
	// one memory instruction: address, grant without done, then words
	task automatic mem_op(logic [2:0] fmt, logic st, logic [19:0] base, logic [3:0] l);
		int k, n;
		lat = l;
		issue({MCP_ESC_PREFIX, fmt}, {4'h0, st, 3'h0});
		host_addr_valid_i = 1;
		host_addr_i = base;
		n = 0;
		while (!bus_req_o && n < 20)
		begin
			tick(1);
			n++;
		end
		host_addr_valid_i = 0;
		check("bus_req_o", bus_req_o, 1);
		bus_grant_i = 1;
		tick(3);
		check("bus_own_o before done", bus_own_o, 0);
		host_instr_done_i = 1;
		tick(1);
		host_instr_done_i = 0;
		k = 0;
		n = 0;
		while (busy_o && n < 200)
		begin
			@(negedge core_clk_i);
			if (mem_ack_i)
			begin
				check("word addr", mem_req_o.addr, base + 2 * k);
				k++;
			end
			n++;
		end
		tick(1);
		bus_grant_i = 0;
		check("word count", k, words[fmt]);
		check("bus_req_o after", bus_req_o, 0);
		exp_top = st ? exp_top + 1 : exp_top - 1;
		check("stack_top_o", stack_top_o, exp_top[2:0]);
	endtask
	// every format loaded, answer latency set to the format code, rising from 0 to 6
	task automatic t_loads;
		for (int f = 0; f < 7; f++)
			mem_op(f[2:0], 1'b0, 20'h00020, f[3:0]);
	endtask
	// load a short integer, store it elsewhere, compare the words
	task automatic t_store;
		mem_op(MCP_FMT_INT32, 1'b0, 20'h00010, 4'h1);
		mem_op(MCP_FMT_INT32, 1'b1, 20'h00040, 4'h2);
		check("stored low", i_host.mem_q[32], 16'h8008);
		check("stored high", i_host.mem_q[33], 16'h8009);
		// fixed use: clear the register at the top by its absolute index, then store it
		fixed_set_mode_i = 1;
		issue({MCP_ESC_PREFIX, 3'h0}, {MCP_MOD_REG, MCP_OP_CLR, exp_top[2:0]});
		tick(13);
		check("busy_o after clear", busy_o, 0);
		mem_op(MCP_FMT_INT32, 1'b1, 20'h00040, 4'h0);
		check("cleared low", i_host.mem_q[32], 16'h0000);
		check("cleared high", i_host.mem_q[33], 16'h0000);
	endtask

	// ----------------------------------------------------------------
	// main sequence and watchdog
	// ----------------------------------------------------------------
	initial
	begin
		tick(20);
		check("busy_o reset", busy_o, 0);
		check("stack_top_o reset", stack_top_o, MCP_TOP_RST);
		rst_i = 0;
		tick(1);
		t_foreign();
		t_regop();
		t_loads();
		t_store();
		test_done();
	end
	// the whole run takes a few hundred cycles
	initial
	begin
		repeat (20000) @(posedge core_clk_i);
		err_count++;
		test_done();
	end
endmodule
`default_nettype wire
